// *** rtl/supervisor_pkg.sv ***
// supervisor_pkg: constants shared by the upgrade supervisor files
// assumes one 250 MHz clock
package supervisor_pkg;

  // serial flash copy window
  localparam logic [23:0] SF_IMAGE_BASE = 24'h90_0000;  // new image start
  localparam logic [23:0] PF_IMAGE_BASE = 24'h00_0000;  // source image start
  localparam logic [23:0] IMAGE_BYTES   = 24'h10_0000;  // bytes copied

  // timing
  localparam int CLK_NS         = 4;          // system clock period
  localparam int EXT_CLK_NS     = 100;        // 10 MHz clock period
  localparam int KICK_EXT_CYC   = 33554432;   // kick interval, 10 MHz cycles
  localparam int KICK_CYC       = KICK_EXT_CYC * (EXT_CLK_NS / CLK_NS);
  localparam int WD_TIMEOUT_CYC = 40894464;   // timeout, 10 MHz cycles
  localparam int WD_UNIT_CYC    = 131072;     // timeout field granularity
  localparam int BLINK_HALF_MS  = 250;        // blink half period
  localparam int BLINK_CYC      = BLINK_HALF_MS * (1000000 / CLK_NS);
  localparam logic [1:0] BOOT_WAIT = 2'h3;    // strap settle cycles

  // parameter codes
  localparam logic [2:0] PRM_SOURCE  = 3'h0;
  localparam logic [2:0] PRM_WD_TIME = 3'h2;
  localparam logic [2:0] PRM_WD_EN   = 3'h3;
  localparam logic [2:0] PRM_PAGE    = 3'h4;
  localparam logic [2:0] PRM_ANF     = 3'h5;
  localparam logic [23:0] WD_TIME_VAL = 24'(WD_TIMEOUT_CYC / WD_UNIT_CYC);
  localparam logic [23:0] ONE_24      = 24'h00_0001;
  localparam logic [1:0]  LAST_STEP   = 2'h3;

  // source bit positions
  localparam int SRC_CRC         = 0;
  localparam int SRC_STATUS_PIN  = 1;
  localparam int SRC_CORE_RESTART = 2;
  localparam int SRC_EXT_RESTART = 3;
  localparam int SRC_WDOG        = 4;

  // led pattern: on and blink bits
  typedef struct packed {
    logic [2:0] on;
    logic [2:0] blink;
  } led_pat_t;

  // register map, byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam int CTRL_KICK_EN  = 0;
  localparam int CTRL_START    = 1;
  localparam int CTRL_COPY_EN  = 2;
  localparam logic [2:0] CTRL_RST = 3'h5;
  localparam int IRQ_SRC_READ  = 0;
  localparam int IRQ_COPY_DONE = 1;
  localparam int IRQ_POF       = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

endpackage

// *** rtl/copy_if.sv ***
// copy_if: supervisor to copier link
// assumes both ends share clk
`timescale 1ns/1ns
interface copy_if;
  logic        go;       // copy wanted
  logic        hold;     // hold pin
  logic        done;     // end pulse
  logic        active;   // copy running
  logic [23:0] pf_addr;  // pf address
  logic        pf_rd;    // parallel flash read pulse
  logic [7:0]  pf_data;  // parallel flash byte
  logic        pf_valid; // byte valid
  logic [23:0] sf_addr;  // sf address
  logic [7:0]  sf_data;  // serial flash byte
  logic        sf_wr;    // serial flash write pulse
  logic        sf_busy;  // serial flash busy

  modport engine (input go, hold, pf_data, pf_valid, sf_busy,
                  output done, active, pf_addr, pf_rd, sf_addr, sf_data, sf_wr);
  modport ctrl   (output go, hold, pf_data, pf_valid, sf_busy,
                  input done, active, pf_addr, pf_rd, sf_addr, sf_data, sf_wr);
endinterface

// *** rtl/image_copier.sv ***
// image_copier: byte copy into serial flash
// assumes pf_valid answers pf_rd
`timescale 1ns/1ns
module image_copier
  import supervisor_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  copy_if.engine   cp
);
  typedef enum logic [4:0] {
    C_IDLE  = 5'h01,
    C_READ  = 5'h02,
    C_WRITE = 5'h04,
    C_WAIT  = 5'h08,
    C_DONE  = 5'h10
  } c_state_t;

  c_state_t    state_q;  // copy sequence
  logic [23:0] cnt_q;    // bytes written
  logic        pf_rd_q;  // read pulse
  logic        sf_wr_q;  // write pulse
  logic [7:0]  data_q;   // byte in flight

  assign cp.pf_rd   = pf_rd_q;
  assign cp.sf_wr   = sf_wr_q;
  assign cp.sf_data = data_q;
  assign cp.pf_addr = PF_IMAGE_BASE + cnt_q;
  assign cp.sf_addr = SF_IMAGE_BASE + cnt_q;  // [RULE1]
  assign cp.done    = (state_q == C_DONE);
  assign cp.active  = (state_q != C_IDLE);

  ////////////////////////////////////////////////////////////////
  // read, write, wait for flash, repeat
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= C_IDLE;
      cnt_q   <= 24'h0;
      pf_rd_q <= 1'b0;
      sf_wr_q <= 1'b0;
      data_q  <= 8'h0;
    end
    else
    begin
      pf_rd_q <= 1'b0;
      sf_wr_q <= 1'b0;
      case (state_q)
        C_IDLE:
        begin
          // low hold lets copy start
          if (cp.go && !cp.hold)  // [RULE4]
          begin
            state_q <= C_READ;
            pf_rd_q <= 1'b1;
          end
        end
        C_READ:
        begin
          if (cp.hold)
            state_q <= C_IDLE;
          else if (cp.pf_valid)
          begin
            data_q  <= cp.pf_data;
            sf_wr_q <= 1'b1;  // [RULE1]
            state_q <= C_WRITE;
          end
        end
        C_WRITE: state_q <= C_WAIT;
        C_WAIT:
        begin
          // next byte once flash free
          if (!cp.sf_busy)
          begin
            if (cnt_q == IMAGE_BYTES - ONE_24)
              state_q <= C_DONE;
            else if (cp.hold)
            begin
              cnt_q   <= cnt_q + ONE_24;
              state_q <= C_IDLE;
            end
            else
            begin
              cnt_q   <= cnt_q + ONE_24;
              pf_rd_q <= 1'b1;
              state_q <= C_READ;
            end
          end
        end
        C_DONE:
        begin
          cnt_q   <= 24'h0;
          state_q <= C_IDLE;
        end
        default: state_q <= C_IDLE;
      endcase
    end
  end
endmodule

// *** rtl/upgrade_supervisor.sv ***
// upgrade_supervisor: factory and app logic
// source read, param writes, watchdog kicks,
// image copy and status leds
// assumes ports on clk;
// straps, buttons async
`timescale 1ns/1ns

// Behaviour
// RULE1 - copy new image to serial flash at 0x900000
// RULE2 - application reconfigures to factory after copy
// RULE3 - factory reads source then loads new image
// RULE4 - hold pin low runs copy, high stops
// RULE5 - application periodically restarts the watchdog
// RULE6 - missed restart reloads factory, source recorded
// RULE7 - factory programs 40,894,464 cycle watchdog timeout
// RULE8 - restart every 33,554,432 ten-MHz cycles
// RULE9 - factory shows source on three leds
// RULE10 - power up shows all leds on
// RULE11 - status pin error 000, crc error 010
// RULE12 - core restart 101, external restart 001
// RULE13 - watchdog expiry shows 110
// RULE14 - invalid image: led2 blinks, others off
// RULE15 - application idle: led1 on, others blink
// RULE16 - application copying: all three blink
// RULE17 - one on, zero off, x blinking
// RULE18 - source read: param zero, strobe, await busy
// RULE19 - blink from divided clock, visible rate
module upgrade_supervisor
  import supervisor_pkg::*;
#(
  parameter int KICK_COUNT  = KICK_CYC,   // watchdog restart interval
  parameter int BLINK_COUNT = BLINK_CYC   // blink half period
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        app_image_pin,
  input  wire logic        update_hold_pin,
  input  wire logic        start_write_pin,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic      [2:0]  ru_param,
  output logic             ru_read,
  output logic             ru_write,
  output logic      [23:0] ru_data_in,
  input  wire logic        ru_busy,
  input  wire logic [23:0] ru_data_out,
  input  wire logic        ru_pof_error,
  output logic             ru_reconfig,
  output logic             wd_reset,
  output logic      [23:0] pf_addr,
  output logic             pf_rd,
  input  wire logic [7:0]  pf_data,
  input  wire logic        pf_valid,
  output logic      [23:0] sf_addr,
  output logic      [7:0]  sf_data,
  output logic             sf_wr,
  input  wire logic        sf_busy,
  output logic      [2:0]  led
);
  import supervisor_pkg::*;

  typedef enum logic [7:0] {
    F_BOOT   = 8'h01,
    F_READ   = 8'h02,
    F_RWAIT  = 8'h04,
    F_REPORT = 8'h08,
    F_WRITE  = 8'h10,
    F_WWAIT  = 8'h20,
    F_RECONF = 8'h40,
    F_APP    = 8'h80
  } f_state_t;

  ////////////////////////////////////////////////////////////////
  // functions

  // led pattern for a source word
  function automatic led_pat_t src_pattern(input logic [4:0] s);
    led_pat_t p;
    p.blink = 3'h0;
    if (s[SRC_WDOG])
      p.on = 3'h6;                  // [RULE13]
    else if (s[SRC_EXT_RESTART])
      p.on = 3'h1;                  // [RULE12]
    else if (s[SRC_CORE_RESTART])
      p.on = 3'h5;                  // [RULE12]
    else if (s[SRC_CRC])
      p.on = 3'h2;                  // [RULE11]
    else if (s[SRC_STATUS_PIN])
      p.on = 3'h0;                  // [RULE11]
    else
      p.on = 3'h7;                  // [RULE10]
    return p;
  endfunction

  // param code and value per step
  function automatic logic [26:0] step_word(input logic [1:0] i);
    case (i)
      2'h0:    return {PRM_PAGE, SF_IMAGE_BASE};  // [RULE3]
      2'h1:    return {PRM_WD_TIME, WD_TIME_VAL}; // [RULE7]
      2'h2:    return {PRM_WD_EN, ONE_24};        // [RULE7]
      default: return {PRM_ANF, ONE_24};          // [RULE3]
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0]  sync1_q;      // sync stage 1
  logic [2:0]  sync2_q;      // sync stage 2
  logic        app_q;        // app image running
  f_state_t    f_state_q;    // factory sequence
  logic [1:0]  boot_q;       // strap settle counter
  logic [1:0]  step_q;       // parameter write step
  logic        seen_q;       // busy seen high
  logic [4:0]  src_q;        // captured source
  logic        src_ev;       // source captured
  logic        pof_q;        // invalid image observed
  logic        pof_d1_q;     // pof edge detect
  logic        copied_q;     // copy finished once
  logic [2:0]  ctrl_q;       // control register
  logic [2:0]  irq_stat_q;   // sticky events
  logic [2:0]  irq_mask_q;   // event mask
  logic [2:0]  irq_ev;       // events this cycle
  logic [2:0]  irq_stat_d;   // next sticky value
  logic        start_req;    // start pin or soft start
  logic [31:0] kick_cnt_q;   // restart timer
  logic [31:0] blink_cnt_q;  // blink divider
  logic        blink_q;      // blink phase
  led_pat_t    pat;          // current led pattern
  logic [31:0] rd_word;      // read mux
  logic        wr_ctrl;      // control write
  copy_if      cp ();        // copier link

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {start_write_pin, update_hold_pin, app_image_pin};
      sync2_q <= sync1_q;
    end
  end

  assign start_req = sync2_q[2] | ctrl_q[CTRL_START];
  assign wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);

  ////////////////////////////////////////////////////////////////
  // factory: read source, report, write params, reconfigure
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      f_state_q  <= F_BOOT;
      boot_q     <= 2'h0;
      step_q     <= 2'h0;
      seen_q     <= 1'b0;
      src_q      <= 5'h0;
      app_q      <= 1'b0;
      ru_param   <= 3'h0;
      ru_read    <= 1'b0;
      ru_write   <= 1'b0;
      ru_data_in <= 24'h0;
    end
    else
    begin
      ru_read  <= 1'b0;
      ru_write <= 1'b0;
      case (f_state_q)
        F_BOOT:
        begin
          // latch image type once strap settled
          boot_q <= boot_q + 2'h1;
          if (boot_q == BOOT_WAIT)
          begin
            app_q <= sync2_q[0];
            if (sync2_q[0])
              f_state_q <= F_APP;
            else
            begin
              ru_param  <= PRM_SOURCE;  // [RULE18]
              ru_read   <= 1'b1;        // [RULE18]
              f_state_q <= F_READ;
            end
          end
        end
        F_READ:
        begin
          // busy rises after the strobe
          seen_q    <= 1'b0;
          f_state_q <= F_RWAIT;
        end
        F_RWAIT:
        begin
          if (ru_busy)
            seen_q <= 1'b1;
          else if (seen_q)
          begin
            src_q     <= ru_data_out[4:0];  // [RULE18]
            f_state_q <= F_REPORT;
          end
        end
        F_REPORT:
        begin
          // hold source until start
          if (start_req)
          begin
            step_q    <= 2'h0;
            f_state_q <= F_WRITE;
          end
        end
        F_WRITE:
        begin
          {ru_param, ru_data_in} <= step_word(step_q);
          ru_write  <= 1'b1;
          seen_q    <= 1'b0;
          f_state_q <= F_WWAIT;
        end
        F_WWAIT:
        begin
          if (ru_busy)
            seen_q <= 1'b1;
          else if (seen_q && !ru_write)
          begin
            step_q <= step_q + 2'h1;
            if (step_q == LAST_STEP)
              f_state_q <= F_RECONF;  // [RULE3]
            else
              f_state_q <= F_WRITE;
          end
        end
        F_RECONF:
        begin
          // refused image: report, wait again
          if (ru_pof_error)
            f_state_q <= F_REPORT;
        end
        F_APP:   f_state_q <= F_APP;
        default: f_state_q <= F_BOOT;
      endcase
    end
  end

  assign src_ev = (f_state_q == F_RWAIT) && !ru_busy && seen_q;

  ////////////////////////////////////////////////////////////////
  // reconfig pulse: factory to new, app to factory
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ru_reconfig <= 1'b0;
    else
      ru_reconfig <= ((f_state_q == F_WWAIT) && (step_q == LAST_STEP)
                      && seen_q && !ru_busy)           // [RULE3]
                     || (app_q && cp.done);            // [RULE2]
  end

  ////////////////////////////////////////////////////////////////
  // invalid image flag, copy done
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pof_q    <= 1'b0;
      pof_d1_q <= 1'b0;
      copied_q <= 1'b0;
    end
    else
    begin
      pof_d1_q <= ru_pof_error;
      if (ru_pof_error)
        pof_q <= 1'b1;  // [RULE14]
      else if (f_state_q == F_WRITE)
        pof_q <= 1'b0;
      if (cp.done)
        copied_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // image copier
  assign cp.go       = app_q && ctrl_q[CTRL_COPY_EN] && !copied_q;
  assign cp.hold     = sync2_q[1];  // [RULE4]
  assign cp.pf_data  = pf_data;
  assign cp.pf_valid = pf_valid;
  assign cp.sf_busy  = sf_busy;
  assign pf_addr     = cp.pf_addr;
  assign pf_rd       = cp.pf_rd;
  assign sf_addr     = cp.sf_addr;
  assign sf_data     = cp.sf_data;
  assign sf_wr       = cp.sf_wr;

  image_copier u_copier (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cp      (cp)
  );

  ////////////////////////////////////////////////////////////////
  // watchdog restart pulse per interval
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      kick_cnt_q <= 32'h0;
      wd_reset   <= 1'b0;
    end
    else
    begin
      wd_reset <= 1'b0;
      if (!app_q || !ctrl_q[CTRL_KICK_EN])
        kick_cnt_q <= 32'h0;  // a stalled kick lets the timer expire [RULE6]
      else if (kick_cnt_q == 32'(KICK_COUNT - 1))
      begin
        kick_cnt_q <= 32'h0;
        wd_reset   <= 1'b1;  // [RULE5] [RULE8]
      end
      else
        kick_cnt_q <= kick_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // blink divider
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end
    else if (blink_cnt_q == 32'(BLINK_COUNT - 1))
    begin
      blink_cnt_q <= 32'h0;
      blink_q     <= ~blink_q;  // [RULE19]
    end
    else
      blink_cnt_q <= blink_cnt_q + 32'h1;
  end

  ////////////////////////////////////////////////////////////////
  // led pattern selection
  always_comb
  begin
    pat = src_pattern(src_q);  // [RULE9]
    if (app_q)
    begin
      if (cp.active)
        pat = '{on: 3'h0, blink: 3'h7};  // [RULE16]
      else
        pat = '{on: 3'h2, blink: 3'h5};  // [RULE15]
    end
    else if (pof_q)
      pat = '{on: 3'h0, blink: 3'h4};    // [RULE14]
    else if (f_state_q == F_BOOT || f_state_q == F_READ || f_state_q == F_RWAIT)
      pat = '{on: 3'h0, blink: 3'h0};
  end

  // blink bits follow the phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      led <= 3'h0;
    else
      led <= pat.on | (pat.blink & {3{blink_q}});  // [RULE17]
  end

  ////////////////////////////////////////////////////////////////
  // control and mask registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q     <= CTRL_RST;
      irq_mask_q <= IRQ_RST;
    end
    else
    begin
      ctrl_q[CTRL_START] <= 1'b0;  // soft start is a pulse
      if (wr_ctrl)
        ctrl_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == OFS_IRQ_MASK)
        irq_mask_q <= reg_wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // sticky events: set beats clear
  always_comb
  begin
    irq_ev                = 3'h0;
    irq_ev[IRQ_SRC_READ]  = src_ev;
    irq_ev[IRQ_COPY_DONE] = cp.done;
    irq_ev[IRQ_POF]       = ru_pof_error && !pof_d1_q;
    irq_stat_d            = irq_stat_q;
    if (reg_wr && reg_addr == OFS_IRQ_STAT)
      irq_stat_d = irq_stat_q & ~reg_wdata[2:0];
    irq_stat_d = irq_stat_d | irq_ev;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_stat_q <= IRQ_RST;
      irq        <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq        <= |(irq_stat_d & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////
  // read mux, unmapped read zero
  always_comb
  begin
    rd_word = 32'h0;
    case (reg_addr)
      OFS_CTRL:     rd_word[2:0] = ctrl_q;
      OFS_STATUS:   rd_word[10:0] = {led, pof_q, cp.active, app_q, src_q};
      OFS_IRQ_STAT: rd_word[2:0] = irq_stat_q;
      OFS_IRQ_MASK: rd_word[2:0] = irq_mask_q;
      default:      rd_word = 32'h0;
    endcase
  end

  // data only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= rd_word;
    else
      reg_rdata <= 32'h0;
  end
endmodule

// *** tb/supervisor_assertions.sv ***
// supervisor_assertions: port checks on upgrade_supervisor
// assumes one clock domain
`timescale 1ns/1ns
module supervisor_assertions
  import supervisor_pkg::*;
#(
  parameter int KICK_COUNT = 50
)
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0]  ru_param,
  input wire logic        ru_read,
  input wire logic        ru_write,
  input wire logic [23:0] ru_data_in,
  input wire logic        ru_busy,
  input wire logic        ru_reconfig,
  input wire logic        wd_reset,
  input wire logic [23:0] pf_addr,
  input wire logic [7:0]  pf_data,
  input wire logic        pf_valid,
  input wire logic [23:0] sf_addr,
  input wire logic [7:0]  sf_data,
  input wire logic        sf_wr
);
  int   kick_cnt;  // cycles since last restart
  logic kick_seen; // a restart was seen
  //////////////////////////////
  // restart interval counter
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      kick_cnt  <= 0;
      kick_seen <= 1'b0;
    end
    else if (wd_reset)
    begin
      kick_cnt  <= 0;
      kick_seen <= 1'b1;
    end
    else
      kick_cnt <= kick_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_source_read: assert property (ru_read |-> ru_param == PRM_SOURCE ##1 !ru_read)
    else $error("source read malformed");
  a_wd_timeout: assert property (ru_write && ru_param == PRM_WD_TIME |-> ru_data_in == WD_TIME_VAL)
    else $error("timeout value wrong");
  a_page_base: assert property (ru_write && ru_param == PRM_PAGE |-> ru_data_in == SF_IMAGE_BASE)
    else $error("image page wrong");
  a_reconfig_late: assert property (ru_reconfig && ru_param == PRM_ANF |-> $past(ru_busy, 2) && !$past(ru_busy))
    else $error("reconfig before busy fell");
  a_kick_gap: assert property (wd_reset && kick_seen |-> kick_cnt == KICK_COUNT - 1)
    else $error("restart interval wrong");
  a_kick_pulse: assert property (wd_reset |=> !wd_reset)
    else $error("restart pulse too long");
  a_sf_addr_map: assert property (sf_wr |-> sf_addr == SF_IMAGE_BASE + pf_addr)
    else $error("serial address wrong");
  a_sf_data_pass: assert property (sf_wr |-> $past(pf_valid) && sf_data == $past(pf_data))
    else $error("serial byte wrong");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside slot");
  c_reconfig: cover property (ru_reconfig);
  c_kick: cover property (wd_reset);
  c_copy: cover property (sf_wr);
endmodule

bind upgrade_supervisor supervisor_assertions #(.KICK_COUNT(KICK_COUNT)) i_supervisor_assertions (.*);

// *** tb/remote_update_model.sv ***
// remote_update_model: remote update circuit and both flashes
// assumes one-cycle strobes
`timescale 1ns/1ns
module remote_update_model
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        slow,
  input wire logic [4:0]  src,
  input wire logic        ru_read,
  input wire logic        ru_write,
  output logic            ru_busy,
  output logic     [23:0] ru_data_out,
  input wire logic        pf_rd,
  input wire logic [23:0] pf_addr,
  output logic     [7:0]  pf_data,
  output logic            pf_valid,
  input wire logic        sf_wr,
  output logic            sf_busy
);
  logic [3:0] rb_q; // remote busy countdown
  logic [3:0] sb_q; // serial busy countdown
  assign ru_busy = rb_q != 4'h0;
  // garbage while busy
  assign ru_data_out = ru_busy ? ~{19'h0, src} : {19'h0, src};
  assign sf_busy = sb_q != 4'h0;
  //////////////////////////////
  // busy timing and byte reads
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rb_q     <= 4'h0;
      sb_q     <= 4'h0;
      pf_valid <= 1'b0;
      pf_data  <= 8'hFF;
    end
    else
    begin
      if (ru_read || ru_write)
        rb_q <= slow ? 4'h9 : 4'h2;
      else if (ru_busy)
        rb_q <= rb_q - 4'h1;
      if (sf_wr)
        sb_q <= slow ? 4'h6 : 4'h1;
      else if (sf_busy)
        sb_q <= sb_q - 4'h1;
      pf_valid <= pf_rd;
      pf_data  <= pf_rd ? pf_addr[7:0] ^ 8'h5A : ~pf_data;
    end
  end
endmodule

// *** tb/tb.sv ***
// tb: self-checking bench for upgrade_supervisor
// assumes short kick and blink counts
`timescale 1ns/1ns
module tb;
  import supervisor_pkg::*;
  logic        clk, sys_rst, app_image_pin, update_hold_pin, start_write_pin, reg_wr, reg_rd;
  logic        irq, ru_read, ru_write, ru_busy, ru_pof_error, ru_reconfig, wd_reset;
  logic        pf_rd, pf_valid, sf_wr, sf_busy, slow;
  logic [7:0]  reg_addr, pf_data, sf_data;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic [23:0] ru_data_in, ru_data_out, pf_addr, sf_addr;
  logic [2:0]  ru_param, led, wp[4];
  logic [4:0]  src;
  int          err_total, check_count, kicks, wrs, nw, n;
  upgrade_supervisor #(.KICK_COUNT(50), .BLINK_COUNT(8)) i_upgrade_supervisor (.*);
  remote_update_model i_remote_update_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  //////////////////////////////
  // shared tasks
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic boot(input logic app, input logic [4:0] s);
    app_image_pin <= app;
    src           <= s;
    sys_rst       <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk("reg_rdata", ex, reg_rdata);
  endtask
  task automatic await_reconfig();
    n = 0;
    while (ru_reconfig !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 500)
    begin
      err_total++;
      end_sim();
    end
  endtask
  // led bit toggles in 40 cycles
  task automatic blink(input int b, input logic ex);
    int t;
    logic p;
    t = 0;
    p = led[b];
    repeat (40)
    begin
      @(posedge clk);
      if (led[b] !== p)
        t++;
      p = led[b];
    end
    chk("blink", 32'(ex), 32'(t > 2));
  endtask
  function automatic logic [2:0] led_exp(input logic [4:0] s);
    if (s[4]) return 3'b110;
    if (s[3]) return 3'b001;
    if (s[2]) return 3'b101;
    if (s[0]) return 3'b010;
    if (s[1]) return 3'b000;
    return 3'b111;
  endfunction
  //////////////////////////////
  // monitor: kicks, writes, bytes
  always @(posedge clk)
  begin
    if (wd_reset === 1'b1)
      kicks++;
    if (ru_write === 1'b1 && nw < 4)
      wp[nw] = ru_param;
    if (ru_write === 1'b1)
      nw++;
    if (sf_wr === 1'b1)
    begin
      chk("sf_addr", 32'(24'h90_0000 + 24'(wrs)), 32'(sf_addr));
      chk("sf_data", 32'(8'(wrs) ^ 8'h5A), 32'(sf_data));
      wrs++;
    end
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    end_sim();
  end
  //////////////////////////////
  // main sequence
  initial
  begin
    {sys_rst, app_image_pin, update_hold_pin, start_write_pin, reg_wr, reg_rd, ru_pof_error} = 7'h50;
    {reg_addr, reg_wdata, src, slow} = 0;
    seed = 32'hA106E1B7;
    // single sources, then random
    for (int i = 0; i < 9; i++)
    begin
      slow <= 1'($random(seed));
      boot(1'b0, i < 6 ? 5'(i == 0 ? 0 : 1 << (i - 1)) : 5'($random(seed)));
      repeat (30) @(posedge clk);
      chk("led", 32'(led_exp(src)), 32'(led));
      rd(OFS_STATUS, {21'h0, led, 3'h0, src});
    end
    rd(OFS_CTRL, 32'h5);
    rd(8'h10, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    // start pin: four writes, then reconfig
    nw = 0;
    start_write_pin <= 1'b1;
    await_reconfig();
    start_write_pin <= 1'b0;
    chk("writes", 32'h4, 32'(nw));
    for (int k = 0; k < 4; k++)
      chk("param", 32'(k == 0 ? 4 : k == 3 ? 5 : k + 1), 32'(wp[k]));
    // invalid image, soft start
    boot(1'b0, 5'h0);
    repeat (30) @(posedge clk);
    ru_pof_error <= 1'b1;
    wr(OFS_CTRL, 32'h7);
    await_reconfig();
    repeat (5) @(posedge clk);
    chk("led_low", 32'h0, 32'(led[1:0]));
    blink(2, 1'b1);
    // app, copy held
    ru_pof_error <= 1'b0;
    boot(1'b1, 5'h0);
    kicks = 0;
    wrs = 0;
    repeat (180) @(posedge clk);
    chk("kicks", 32'h3, 32'(kicks));
    chk("led1", 32'h1, 32'(led[1]));
    blink(2, 1'b1);
    blink(1, 1'b0);
    chk("held", 32'h0, 32'(wrs));
    // copy runs, pauses, resumes
    update_hold_pin <= 1'b0;
    slow <= 1'b1;
    repeat (100) @(posedge clk);
    blink(1, 1'b1);
    blink(0, 1'b1);
    chk("copying", 32'h1, 32'(wrs > 4));
    update_hold_pin <= 1'b1;
    repeat (20) @(posedge clk);
    n = wrs;
    repeat (60) @(posedge clk);
    chk("paused", 32'(n), 32'(wrs));
    update_hold_pin <= 1'b0;
    repeat (40) @(posedge clk);
    chk("resumed", 32'h1, 32'(wrs > n));
    end_sim();
  end
endmodule
